// file: logic/lsr_pkg.sv
package lsr_pkg;
    // register addresses on the serial interface
    localparam logic [7:0] LSR_ADDR_S1_LSB = 8'h21;
    localparam logic [7:0] LSR_ADDR_S1_MSB = 8'h22;
    localparam logic [7:0] LSR_ADDR_S2_LSB = 8'h23;
    localparam logic [7:0] LSR_ADDR_S2_MSB = 8'h24;
    // field layout
    localparam int LSR_RESULT_W = 13;
    localparam int LSR_LSB_HI = 7;
    localparam int LSR_MSB_LO = 8;
    localparam int LSR_MSB_HI = 12;
    localparam logic [2:0] LSR_RSVD_VALUE = 3'h0;
    localparam logic [12:0] LSR_RESULT_RESET = 13'h0000;
    localparam logic [7:0] LSR_UNMAPPED_VALUE = 8'h00;
    // refresh period
    localparam int LSR_CLK_HZ = 100_000_000;
    localparam int LSR_REFRESH_MS = 80;
    localparam int LSR_REFRESH_CYCLES = LSR_CLK_HZ / 1000 * LSR_REFRESH_MS;
    localparam int LSR_NUM_SENSORS = 2;

    // register read/write request from the serial interface engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsr_req_type;

    // read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lsr_rsp_type;
endpackage

// file: logic/lsr_snapshot.sv
`timescale 1ns/1ps
`default_nettype none
// holds one sensor's result; both halves come from one conversion
module lsr_snapshot
    import lsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [12:0] sample,
    output logic [12:0] value
);
    typedef struct packed {
        logic [12:0] value;
    } lsr_snap_state_type;

    lsr_snap_state_type state_q;
    lsr_snap_state_type state_d;

    // whole word loads at once so halves never mix
    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d.value = sample; // see RULE_07
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '{value: LSR_RESULT_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.value;
endmodule // lsr_snapshot
`default_nettype wire

// file: logic/lsr_readout.sv
// Behaviour
// RULE_01: sensor 1 low register shows result bits 7..0.
// RULE_02: sensor 1 high register shows result bits 12..8 in 4..0; with a sensor 2 low read pending the code returns sensor 2's bits.
// RULE_03: sensor 2 low register shows result bits 7..0.
// RULE_04: sensor 2 high register shows result bits 12..8 in 4..0; with a sensor 1 low read pending the code returns sensor 1's bits.
// RULE_05: results refresh every 80 ms only while that sensor is enabled.
// RULE_06: all four result registers are read-only; writes are ignored.
// RULE_07: reserved bits read zero; a read pair comes from one conversion; the code shares one msb_hold that a low read of either sensor reloads.
`timescale 1ns/1ps
`default_nettype none
module lsr_readout
    import lsr_pkg::*;
#(
    parameter int REFRESH_CYCLES = LSR_REFRESH_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] sensor_enable,
    input wire logic [12:0] sensor1_sample,
    input wire logic [12:0] sensor2_sample,
    input wire lsr_req_type req,
    output lsr_rsp_type rsp,
    output logic [1:0] refresh_pulse
);
    typedef struct packed {
        logic [31:0] tick_cnt;
        logic [1:0] refresh;
        logic msb_pending;
        logic [4:0] msb_hold;
        lsr_rsp_type rsp;
    } lsr_state_type;

    lsr_state_type state_q;
    lsr_state_type state_d;
    logic [12:0] value [LSR_NUM_SENSORS];
    logic [12:0] sample [LSR_NUM_SENSORS];
    logic tick;

    assign sample[0] = sensor1_sample;
    assign sample[1] = sensor2_sample;
    assign tick = (state_q.tick_cnt == 32'(REFRESH_CYCLES - 1));

    // one snapshot per sensor, loaded only when enabled at the period tick
    genvar g;
    generate
        for (g = 0; g < LSR_NUM_SENSORS; g++) begin : g_snap
            lsr_snapshot u_snap (
                .clk(clk),
                .reset(reset),
                .load(tick && sensor_enable[g]), // see RULE_05
                .sample(sample[g]),
                .value(value[g])
            );
        end
    endgenerate

    // period counter, read decode; writes never touch results
    always_comb begin
        state_d = state_q;
        state_d.refresh = 2'h0;
        state_d.rsp.valid = 1'b0;
        if (tick) begin
            state_d.tick_cnt = 32'h0;
            state_d.refresh = sensor_enable; // see RULE_05
        end else begin
            state_d.tick_cnt = state_q.tick_cnt + 32'h1;
        end
        // req.wr is deliberately unused for result registers, see RULE_06
        if (req.rd) begin
            state_d.rsp.valid = 1'b1;
            if (req.addr == LSR_ADDR_S1_LSB) begin
                state_d.rsp.data = value[0][LSR_LSB_HI:0]; // see RULE_01
                // latch the matching upper half so a later refresh cannot mix
                state_d.msb_pending = 1'b1;
                state_d.msb_hold = value[0][LSR_MSB_HI:LSR_MSB_LO]; // see RULE_07
            end else if (req.addr == LSR_ADDR_S1_MSB) begin
                state_d.rsp.data = {LSR_RSVD_VALUE, state_q.msb_pending ?
                    state_q.msb_hold : value[0][LSR_MSB_HI:LSR_MSB_LO]}; // see RULE_02
                state_d.msb_pending = 1'b0;
            end else if (req.addr == LSR_ADDR_S2_LSB) begin
                state_d.rsp.data = value[1][LSR_LSB_HI:0]; // see RULE_03
                state_d.msb_pending = 1'b1;
                state_d.msb_hold = value[1][LSR_MSB_HI:LSR_MSB_LO]; // see RULE_07
            end else if (req.addr == LSR_ADDR_S2_MSB) begin
                state_d.rsp.data = {LSR_RSVD_VALUE, state_q.msb_pending ?
                    state_q.msb_hold : value[1][LSR_MSB_HI:LSR_MSB_LO]}; // see RULE_04
                state_d.msb_pending = 1'b0;
            end else begin
                state_d.rsp.data = LSR_UNMAPPED_VALUE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rsp = state_q.rsp;
    assign refresh_pulse = state_q.refresh;

    // assertions: read answers, pairing, refresh timing and write immunity

    // one read request of each kind, used to build the pairing properties
    sequence s_low_read_one;
        req.rd && req.addr == LSR_ADDR_S1_LSB;
    endsequence

    sequence s_high_read_one;
        req.rd && req.addr == LSR_ADDR_S1_MSB;
    endsequence

    sequence s_low_read_two;
        req.rd && req.addr == LSR_ADDR_S2_LSB;
    endsequence

    sequence s_high_read_two;
        req.rd && req.addr == LSR_ADDR_S2_MSB;
    endsequence

    // any high-byte read must answer with the reserved bits cleared
    a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        req.rd && (req.addr == LSR_ADDR_S1_MSB || req.addr == LSR_ADDR_S2_MSB)
        |=> rsp.data[7:5] == 3'h0) // see RULE_07
        else $error("reserved bits not zero");
    a_lsb_one: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == LSR_ADDR_S1_LSB |=> rsp.valid
        && rsp.data == $past(value[0][7:0])) // see RULE_01
        else $error("sensor1 lsb wrong");
    a_lsb_two: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == LSR_ADDR_S2_LSB |=> rsp.data == $past(value[1][7:0])) // see RULE_03
        else $error("sensor2 lsb wrong");
    a_msb_one: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == LSR_ADDR_S1_MSB && !state_q.msb_pending
        |=> rsp.data[4:0] == $past(value[0][12:8])) // see RULE_02
        else $error("sensor1 msb wrong");
    a_msb_two: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == LSR_ADDR_S2_MSB && !state_q.msb_pending
        |=> rsp.data[4:0] == $past(value[1][12:8])) // see RULE_04
        else $error("sensor2 msb wrong");
    a_hold_disabled: assert property (@(posedge clk) disable iff (reset)
        !sensor_enable[0] |=> $stable(value[0])) // see RULE_05
        else $error("disabled sensor refreshed");
    a_refresh_tick: assert property (@(posedge clk) disable iff (reset)
        tick && sensor_enable[1] |=> value[1] == $past(sensor2_sample)
        && refresh_pulse[1]) // see RULE_05
        else $error("enabled sensor not refreshed");
    a_write_ignored: assert property (@(posedge clk) disable iff (reset)
        req.wr && !tick |=> $stable(value[0]) && $stable(value[1])) // see RULE_06
        else $error("write altered result");

    // low then high of one sensor must give halves of one conversion,
    // even when a refresh lands between the two reads
    a_pair_one: assert property (@(posedge clk) disable iff (reset)
        s_low_read_one ##1 s_high_read_one
        |=> rsp.data[4:0] == $past(value[0][12:8], 2)) // see RULE_07
        else $error("sensor1 halves mixed");
    a_pair_two: assert property (@(posedge clk) disable iff (reset)
        s_low_read_two ##1 s_high_read_two
        |=> rsp.data[4:0] == $past(value[1][12:8], 2)) // see RULE_07
        else $error("sensor2 halves mixed");

    // a high-byte read consumes the pairing snapshot
    a_pending_clear: assert property (@(posedge clk) disable iff (reset)
        s_high_read_one or s_high_read_two |=> !state_q.msb_pending) // see RULE_07
        else $error("pairing snapshot not cleared");

    // a low-byte read arms the pairing snapshot
    a_pending_set: assert property (@(posedge clk) disable iff (reset)
        s_low_read_one or s_low_read_two |=> state_q.msb_pending) // see RULE_07
        else $error("pairing snapshot not armed");

    // every read is answered exactly one cycle later
    a_read_answered: assert property (@(posedge clk) disable iff (reset)
        req.rd |=> rsp.valid) // see RULE_06
        else $error("read not answered");

    // no read, no answer: writes produce nothing at the ports
    a_write_silent: assert property (@(posedge clk) disable iff (reset)
        !req.rd |=> !rsp.valid) // see RULE_06
        else $error("answer without read");

    // addresses outside the result window read as the fixed filler value
    a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr != LSR_ADDR_S1_LSB && req.addr != LSR_ADDR_S1_MSB
        && req.addr != LSR_ADDR_S2_LSB && req.addr != LSR_ADDR_S2_MSB
        |=> rsp.data == LSR_UNMAPPED_VALUE)
        else $error("unmapped read not zero");

    // the period counter never passes its wrap point
    a_counter_bound: assert property (@(posedge clk) disable iff (reset)
        state_q.tick_cnt < 32'(REFRESH_CYCLES)) // see RULE_05
        else $error("period counter overran");

    // a refresh pulse only follows a tick with that sensor enabled
    a_pulse_enabled: assert property (@(posedge clk) disable iff (reset)
        refresh_pulse[0] |-> $past(tick) && $past(sensor_enable[0])) // see RULE_05
        else $error("sensor1 pulse without enable");
    a_pulse_enabled2: assert property (@(posedge clk) disable iff (reset)
        refresh_pulse[1] |-> $past(tick) && $past(sensor_enable[1])) // see RULE_05
        else $error("sensor2 pulse without enable");

    // sensor 2 is held while disabled, sensor 1 loads at a tick while enabled
    a_hold_disabled2: assert property (@(posedge clk) disable iff (reset)
        !sensor_enable[1] |=> $stable(value[1])) // see RULE_05
        else $error("disabled sensor2 refreshed");
    a_refresh_tick1: assert property (@(posedge clk) disable iff (reset)
        tick && sensor_enable[0] |=> value[0] == $past(sensor1_sample)
        && refresh_pulse[0]) // see RULE_05
        else $error("enabled sensor1 not refreshed");

    // outside a tick neither result may move
    a_no_early_load: assert property (@(posedge clk) disable iff (reset)
        !tick |=> $stable(value[0]) && $stable(value[1])) // see RULE_05
        else $error("result moved between ticks");

    // reset leaves the answer and pulse outputs quiet
    a_reset_quiet: assert property (@(posedge clk)
        reset |=> !rsp.valid && refresh_pulse == 2'h0)
        else $error("outputs busy after reset");
endmodule // lsr_readout
`default_nettype wire

// file: tb/lsr_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// conversion front end: a fresh result every cycle, never steady
module lsr_sensor_model (
    input wire logic clk,
    output logic [12:0] s1,
    output logic [12:0] s2
);
    int seed = 7;
    // new values off the sampling edge so loads never race
    always @(negedge clk) begin
        s1 <= 13'($random(seed));
        s2 <= 13'($random(seed));
    end
endmodule // lsr_sensor_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lsr_pkg::*;
    localparam int R = 20;
    logic clk = 0;
    logic reset = 1;
    logic [1:0] en = 2'h3;
    logic [1:0] en_q, pls;
    logic [12:0] s1, s2;
    logic [12:0] ev [2];
    logic [12:0] sp [2];
    lsr_req_type req = '0;
    lsr_rsp_type rsp;
    int seed = 98, num_errors = 0, comparisons = 0, cyc = 0;
    int last [2];
    logic pend = 0;
    logic [4:0] snap;
    lsr_sensor_model i_fe (.clk(clk), .s1(s1), .s2(s2));
    lsr_readout #(.REFRESH_CYCLES(R)) i_dut (.clk(clk), .reset(reset), .sensor_enable(en),
        .sensor1_sample(s1), .sensor2_sample(s2), .req(req), .rsp(rsp), .refresh_pulse(pls));
    always #5 clk = ~clk;
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // expected contents; load moment from the pulse, period checked against it
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            report_and_stop();
        end
        if (reset) begin
            ev = '{13'h0, 13'h0};
            last = '{-1, -1};
        end
        for (int i = 0; i < 2; i++) begin
            if (pls[i] === 1'b1) begin
                chk("load enable", {7'h0, en_q[i]}, 8'h01);
                if (last[i] >= 0) chk("period", 8'((cyc - last[i]) % R), 8'h00);
                ev[i] = sp[i];
                last[i] = cyc;
            end
        end
        sp = '{s1, s2};
        en_q = en;
    end
    // strobe stays up between accesses; reads expect the shared pairing snapshot
    task automatic acc(logic w, logic [7:0] a);
        logic [12:0] v;
        logic [7:0] d;
        req.rd = !w;
        req.wr = w;
        req.addr = a;
        req.wdata = 8'($random(seed));
        @(negedge clk);
        v = (a < LSR_ADDR_S2_LSB) ? ev[0] : ev[1];
        d = LSR_UNMAPPED_VALUE;
        // writes are ignored, so they must not touch the pairing snapshot either
        if (!w && (a == LSR_ADDR_S1_LSB || a == LSR_ADDR_S2_LSB)) begin
            d = v[7:0];
            pend = 1;
            snap = v[12:8];
        end else if (!w && (a == LSR_ADDR_S1_MSB || a == LSR_ADDR_S2_MSB)) begin
            d = {LSR_RSVD_VALUE, pend ? snap : v[12:8]};
            pend = 0;
        end
        chk("rsp valid", {7'h0, rsp.valid}, {7'h0, !w});
        if (!w) chk("rsp data", rsp.data, d);
    endtask
    // main sequence: corner accesses, then random traffic with enables toggling
    initial begin
        repeat (5) @(negedge clk);
        reset = 0;
        for (int a = 8'h20; a < 8'h26; a++) acc(1'b1, 8'(a));
        for (int a = 8'h20; a < 8'h26; a++) acc(1'b0, 8'(a));
        $display("test corner done");
        repeat (3000) begin
            if ($random(seed) % 8 == 0) en = 2'($random(seed));
            acc(1'($random(seed)) & 1'($random(seed)), 8'h20 + 8'({$random(seed)} % 7));
        end
        req = '0;
        @(negedge clk);
        chk("refreshed", {6'h0, last[1] > 0, last[0] > 0}, 8'h03);
        $display("test random done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
